/* hw/vrei_pkg.sv */
// vrei_pkg: constants and types for the vector relocation and external irq
// block. assumes a 32-bit apb slave and word-aligned registers.
package vrei_pkg;

	////////////////////////////////////////////////////////////////////////
	// register byte offsets
	localparam logic [7:0] VREI_OFS_MCU_CONTROL = 8'h00;
	localparam logic [7:0] VREI_OFS_SENSE_CTRL  = 8'h04;
	localparam logic [7:0] VREI_OFS_IRQ_ENABLE  = 8'h08;
	localparam logic [7:0] VREI_OFS_IRQ_FLAGS   = 8'h0C;
	localparam logic [7:0] VREI_OFS_MASK_LOW    = 8'h10;
	localparam logic [7:0] VREI_OFS_MASK_HIGH   = 8'h14;
	localparam logic [7:0] VREI_OFS_CORE_CTRL   = 8'h18;
	localparam logic [7:0] VREI_OFS_STATUS      = 8'h1C;

	////////////////////////////////////////////////////////////////////////
	// field positions
	localparam int VREI_BIT_UNLOCK      = 0;
	localparam int VREI_BIT_SELECT      = 1;
	localparam int VREI_BIT_EXT         = 0;
	localparam int VREI_BIT_PC_LOW      = 6;
	localparam int VREI_BIT_PC_HIGH     = 7;
	localparam int VREI_BIT_GIE         = 0;
	localparam int VREI_BIT_IN_BOOT     = 1;
	localparam int VREI_BIT_ACK         = 2;
	localparam int VREI_BIT_BLOCKED     = 0;
	localparam int VREI_BIT_LEVEL_LIVE  = 1;

	////////////////////////////////////////////////////////////////////////
	// reset values
	localparam logic [7:0] VREI_RST_MCU_CONTROL = 8'h00;
	localparam logic [7:0] VREI_RST_SENSE_CTRL  = 8'h00;
	localparam logic [7:0] VREI_RST_IRQ_ENABLE  = 8'h00;
	localparam logic [7:0] VREI_RST_MASK        = 8'h00;

	////////////////////////////////////////////////////////////////////////
	// timing: unlock window is four core cycles
	localparam logic [2:0] VREI_UNLOCK_CYCLES   = 3'h4;

	////////////////////////////////////////////////////////////////////////
	// vector table layout
	localparam logic [15:0] VREI_APP_RESET      = 16'h0000;
	localparam logic [15:0] VREI_VEC_STRIDE     = 16'h0002;
	localparam logic [15:0] VREI_BOOT_BASE_2K   = 16'h1C00;
	localparam logic [15:0] VREI_BOOT_BASE_1K   = 16'h1E00;
	localparam logic [15:0] VREI_BOOT_BASE_512  = 16'h1F00;
	localparam logic [15:0] VREI_BOOT_BASE_256  = 16'h1F80;
	localparam logic [15:0] VREI_OFS_VEC_EXT    = 16'h0002;
	localparam logic [15:0] VREI_OFS_VEC_PC_LO  = 16'h0004;
	localparam logic [15:0] VREI_OFS_VEC_PC_HI  = 16'h0006;

	// sense control encodings
	typedef enum logic [1:0] {
		VREI_SENSE_LOW  = 2'h0,
		VREI_SENSE_ANY  = 2'h1,
		VREI_SENSE_FALL = 2'h2,
		VREI_SENSE_RISE = 2'h3
	} vrei_sense_t;

	// fuse and lock straps, sampled after reset
	typedef struct packed {
		logic       boot_reset_fuse;
		logic [1:0] boot_size_fuses;
		logic       app_side_boot_lock;
		logic       boot_side_boot_lock;
	} vrei_fuses_t;

	// dispatch request to the core
	typedef struct packed {
		logic        valid;
		logic [1:0]  source;
		logic [15:0] vector;
	} vrei_dispatch_t;

	localparam logic [1:0] VREI_SRC_EXT   = 2'h0;
	localparam logic [1:0] VREI_SRC_PC_LO = 2'h1;
	localparam logic [1:0] VREI_SRC_PC_HI = 2'h2;

endpackage

/* hw/vrei_pin_sync.sv */
// vrei_pin_sync: two-flop synchroniser per bit for pin inputs.
// assumes inputs are asynchronous to pclk.
module vrei_pin_sync #(
	parameter int WIDTH = 17
) (
	input  wire logic             pclk,
	input  wire logic             presetn,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stage1   <= '0;
			sync_out <= '0;
		end else begin
			stage1   <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

/* hw/vrei_top.sv */
// vrei_top: vector table placement, unlock sequence and external / pin
// change interrupt detection. assumes an apb master and a core that
// pulses irq_ack when it enters the dispatched handler.
//
// How it works
// RL1: software sets unlock, then select within four
// RL2: block interrupts from unlock until after select
// RL3: no select write: block four cycles, release
// RL4: automatic blocking leaves global enable untouched
// RL5: unlock self-clears after four cycles or select
// RL6: select picks app start or boot base
// RL7: boot vectors plus app lock: mute in app
// RL8: app vectors plus boot lock: mute in boot
// RL9: 2K boot base 0x1C00, vectors from 0x1C02
// RL10: pins trigger even when driven as outputs
// RL11: high group pins 15..8, low 7..0
// RL12: per-pin masks gate pin change inputs
// RL13: pin change seen without i/o clock
// RL14: ext pin senses fall, rise or low
// RL15: low level keeps request asserted while low
// RL16: edge detection needs the i/o clock
// RL17: low level detected without i/o clock
// RL18: level gone before start-up: no interrupt
// RL19: sense codes: low, any, fall, rise
// RL20: pin sampled before edge detection
// RL21: flags clear on handler entry or write-one
// RL22: vector equals table base plus source offset
//
// Implementation choices: the placing of the registers and the APB slave port.
module vrei_top
	import vrei_pkg::*;
#(
	parameter int PC_WIDTH = 16
) (
	input  wire logic                pclk,
	input  wire logic                presetn,
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [7:0]          paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic      [31:0]         prdata,
	output logic                     pready,
	output logic                     pslverr,
	input  wire logic                ext_irq_pin,
	input  wire logic [PC_WIDTH-1:0] pin_change_inputs,
	input  wire logic                io_clock_running,
	input  wire vrei_fuses_t         fuse_straps,
	input  wire logic                irq_ack,
	output vrei_dispatch_t           dispatch,
	output logic [15:0]              reset_vector,
	output logic                     pin_wake
);

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [PC_WIDTH:0] pins_sync;
	logic              ext_s;
	logic [PC_WIDTH-1:0] pc_s;

	vrei_pin_sync #(.WIDTH(PC_WIDTH + 1)) u_sync (
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in ({ext_irq_pin, pin_change_inputs}),
		.sync_out (pins_sync)
	);
	assign ext_s = pins_sync[PC_WIDTH];
	assign pc_s  = pins_sync[PC_WIDTH-1:0];

	////////////////////////////////////////////////////////////////////////
	// fuse capture after reset release
	vrei_fuses_t fuses;
	logic        fuses_taken;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuses       <= '0;
			fuses_taken <= 1'b0;
		end else if (!fuses_taken) begin
			fuses       <= fuse_straps;
			fuses_taken <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode
	logic       wr_en;
	logic       rd_en;
	logic       addr_ok;
	logic [7:0] wbyte;

	assign pready  = 1'b1;
	assign wr_en   = psel && penable && pwrite && pstrb[0];
	assign rd_en   = psel && penable && !pwrite;
	assign wbyte   = pwdata[7:0];
	assign addr_ok = (paddr <= VREI_OFS_STATUS) && (paddr[1:0] == 2'h0);
	assign pslverr = psel && penable && !addr_ok;

	////////////////////////////////////////////////////////////////////////
	// vector change unlock sequence
	logic       vector_table_select;
	logic       vector_change_unlock;
	logic [2:0] unlock_count;
	logic       block_tail;
	logic       mcu_wr;

	assign mcu_wr = wr_en && (paddr == VREI_OFS_MCU_CONTROL);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vector_change_unlock <= VREI_RST_MCU_CONTROL[VREI_BIT_UNLOCK];
			vector_table_select  <= VREI_RST_MCU_CONTROL[VREI_BIT_SELECT];
			unlock_count         <= 3'h0;
		end else if (mcu_wr && wbyte[VREI_BIT_UNLOCK]) begin
			vector_change_unlock <= 1'b1;
			unlock_count         <= VREI_UNLOCK_CYCLES;
		end else if (mcu_wr && vector_change_unlock) begin
			vector_table_select  <= wbyte[VREI_BIT_SELECT]; // RL1
			vector_change_unlock <= 1'b0; // RL5
			unlock_count         <= 3'h0;
		end else if (vector_change_unlock) begin
			unlock_count <= unlock_count - 3'h1;
			if (unlock_count == 3'h1) begin
				vector_change_unlock <= 1'b0; // RL5
			end
		end
	end

	// one extra cycle covers the instruction after the select write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			block_tail <= 1'b0;
		end else begin
			block_tail <= mcu_wr && vector_change_unlock
				&& !wbyte[VREI_BIT_UNLOCK]; // RL2
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control registers
	logic [1:0] sense;
	logic [7:0] enables;
	logic [7:0] pin_change_mask_low;
	logic [7:0] pin_change_mask_high;
	logic       gie;
	logic       in_boot;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sense                <= VREI_RST_SENSE_CTRL[1:0];
			enables              <= VREI_RST_IRQ_ENABLE;
			pin_change_mask_low  <= VREI_RST_MASK;
			pin_change_mask_high <= VREI_RST_MASK;
			gie                  <= 1'b0;
			in_boot              <= 1'b0;
		end else if (wr_en) begin
			unique case (paddr)
				VREI_OFS_SENSE_CTRL: begin
					sense <= wbyte[1:0]; // RL14
				end
				VREI_OFS_IRQ_ENABLE: begin
					enables <= wbyte & 8'hC1;
				end
				VREI_OFS_MASK_LOW: begin
					pin_change_mask_low <= wbyte; // RL12
				end
				VREI_OFS_MASK_HIGH: begin
					pin_change_mask_high <= wbyte; // RL12
				end
				VREI_OFS_CORE_CTRL: begin
					gie     <= wbyte[VREI_BIT_GIE]; // RL4
					in_boot <= wbyte[VREI_BIT_IN_BOOT];
				end
				default: begin
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// external pin detection
	logic ext_prev;
	logic ext_edge;
	logic level_low;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_prev <= 1'b1;
		end else if (io_clock_running) begin
			ext_prev <= ext_s; // RL20
		end
	end

	always_comb begin
		unique case (vrei_sense_t'(sense)) // RL19
			VREI_SENSE_ANY: begin
				ext_edge = ext_s != ext_prev;
			end
			VREI_SENSE_FALL: begin
				ext_edge = ext_prev && !ext_s;
			end
			VREI_SENSE_RISE: begin
				ext_edge = !ext_prev && ext_s;
			end
			default: begin
				ext_edge = 1'b0;
			end
		endcase
		ext_edge = ext_edge && io_clock_running; // RL16
	end

	// level is seen regardless of the i/o clock; lost level gives no irq
	assign level_low = (sense == VREI_SENSE_LOW) && !ext_s; // RL15 RL17 RL18

	////////////////////////////////////////////////////////////////////////
	// pin change detection per pin
	logic [PC_WIDTH-1:0] pc_prev;
	logic [PC_WIDTH-1:0] pc_toggle;
	logic [PC_WIDTH-1:0] pc_mask;

	assign pc_mask = {pin_change_mask_high, pin_change_mask_low};

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_prev <= '0;
		end else begin
			pc_prev <= pc_s; // RL13
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < PC_WIDTH; gi++) begin : g_pc
			assign pc_toggle[gi] = (pc_s[gi] ^ pc_prev[gi]) && pc_mask[gi]; // RL10 RL12
		end
	endgenerate

	logic pc_low_hit;
	logic pc_high_hit;

	assign pc_low_hit  = |pc_toggle[7:0]; // RL11
	assign pc_high_hit = |pc_toggle[PC_WIDTH-1:8]; // RL11
	assign pin_wake    = pc_low_hit || pc_high_hit || level_low;

	////////////////////////////////////////////////////////////////////////
	// flags: set wins over clear
	logic ext_irq_flag;
	logic pin_change_flag_low;
	logic pin_change_flag_high;
	logic flag_wr;
	logic ack_ext;
	logic ack_lo;
	logic ack_hi;

	assign flag_wr = wr_en && (paddr == VREI_OFS_IRQ_FLAGS);
	assign ack_ext = irq_ack && dispatch.source == VREI_SRC_EXT;
	assign ack_lo  = irq_ack && dispatch.source == VREI_SRC_PC_LO;
	assign ack_hi  = irq_ack && dispatch.source == VREI_SRC_PC_HI;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_irq_flag         <= 1'b0;
			pin_change_flag_low  <= 1'b0;
			pin_change_flag_high <= 1'b0;
		end else begin
			if (ext_edge) begin
				ext_irq_flag <= 1'b1;
			end else if (sense == VREI_SENSE_LOW
				|| ack_ext || (flag_wr && wbyte[VREI_BIT_EXT])) begin
				ext_irq_flag <= 1'b0; // RL21
			end
			if (pc_low_hit) begin
				pin_change_flag_low <= 1'b1;
			end else if (ack_lo || (flag_wr && wbyte[VREI_BIT_PC_LOW])) begin
				pin_change_flag_low <= 1'b0; // RL21
			end
			if (pc_high_hit) begin
				pin_change_flag_high <= 1'b1;
			end else if (ack_hi || (flag_wr && wbyte[VREI_BIT_PC_HIGH])) begin
				pin_change_flag_high <= 1'b0; // RL21
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// dispatch
	logic [15:0] boot_base;
	logic [15:0] table_base;
	logic        muted;
	logic        blocked;
	logic        ext_req;
	logic        lo_req;
	logic        hi_req;

	always_comb begin
		unique case (fuses.boot_size_fuses)
			2'h0: boot_base = VREI_BOOT_BASE_2K; // RL9
			2'h1: boot_base = VREI_BOOT_BASE_1K;
			2'h2: boot_base = VREI_BOOT_BASE_512;
			default: boot_base = VREI_BOOT_BASE_256;
		endcase
	end

	assign table_base = vector_table_select ? boot_base : VREI_APP_RESET; // RL6
	assign muted = (vector_table_select && fuses.app_side_boot_lock
			&& !in_boot) // RL7
		|| (!vector_table_select && fuses.boot_side_boot_lock
			&& in_boot); // RL8
	assign blocked = vector_change_unlock || block_tail; // RL2 RL3

	assign ext_req = enables[VREI_BIT_EXT] && (ext_irq_flag || level_low);
	assign lo_req  = enables[VREI_BIT_PC_LOW] && pin_change_flag_low;
	assign hi_req  = enables[VREI_BIT_PC_HIGH] && pin_change_flag_high;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dispatch     <= '0;
			reset_vector <= VREI_APP_RESET;
		end else begin
			reset_vector <= fuses.boot_reset_fuse ? VREI_APP_RESET
				: boot_base; // RL22
			dispatch.valid <= gie && !blocked && !muted
				&& (ext_req || lo_req || hi_req); // RL4
			if (ext_req) begin
				dispatch.source <= VREI_SRC_EXT;
				dispatch.vector <= table_base + VREI_OFS_VEC_EXT; // RL22
			end else if (lo_req) begin
				dispatch.source <= VREI_SRC_PC_LO;
				dispatch.vector <= table_base + VREI_OFS_VEC_PC_LO; // RL22
			end else begin
				dispatch.source <= VREI_SRC_PC_HI;
				dispatch.vector <= table_base + VREI_OFS_VEC_PC_HI; // RL22
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read mux
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			unique case (paddr)
				VREI_OFS_MCU_CONTROL: prdata <= {30'h0,
					vector_table_select, vector_change_unlock};
				VREI_OFS_SENSE_CTRL: prdata <= {30'h0, sense};
				VREI_OFS_IRQ_ENABLE: prdata <= {24'h0, enables};
				VREI_OFS_IRQ_FLAGS: prdata <= {24'h0, pin_change_flag_high,
					pin_change_flag_low, 5'h0, ext_irq_flag};
				VREI_OFS_MASK_LOW: prdata <= {24'h0, pin_change_mask_low};
				VREI_OFS_MASK_HIGH: prdata <= {24'h0, pin_change_mask_high};
				VREI_OFS_CORE_CTRL: prdata <= {30'h0, in_boot, gie};
				VREI_OFS_STATUS: prdata <= {30'h0, level_low, blocked};
				default: prdata <= 32'h0000_0000;
			endcase
		end
	end
endmodule

/* tb/vrei_core_model.sv */
// vrei_core_model: core side that enters dispatched handlers.
// assumes dispatch stays valid until it is acknowledged.
module vrei_core_model
	import vrei_pkg::*;
(
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire vrei_dispatch_t dispatch,
	input  wire logic           slow,
	output logic                irq_ack,
	output logic [1:0]          last_src,
	output logic [15:0]         last_vec,
	output int                  n_taken
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [1:0] delay;
	logic [1:0] hold_off;

	////////////////////////////////////////////////////////////
	// slow mode waits three cycles before entering the handler
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			{irq_ack, delay, hold_off, last_src, last_vec} <= '0;
			n_taken <= 0;
		end else begin
			irq_ack <= 1'b0;
			if (hold_off != 2'h0) begin
				hold_off <= hold_off - 2'h1;
			end else if (dispatch.valid && (!slow || delay == 2'h3)) begin
				irq_ack  <= 1'b1;
				hold_off <= 2'h3;
				delay    <= 2'h0;
				last_src <= dispatch.source;
				last_vec <= dispatch.vector;
				n_taken  <= n_taken + 1;
			end else if (dispatch.valid) begin
				delay <= delay + 2'h1;
			end
		end
	end
endmodule

/* tb/vrei_properties.sv */
// vrei_properties: port checks on vrei_top.
// assumes the bind below reaches every vrei_top instance.
module vrei_properties
	import vrei_pkg::*;
(
	input wire logic           pclk,
	input wire logic           presetn,
	input wire logic           psel,
	input wire logic           penable,
	input wire logic           pwrite,
	input wire logic [7:0]     paddr,
	input wire logic [31:0]    pwdata,
	input wire logic [3:0]     pstrb,
	input wire logic [31:0]    prdata,
	input wire logic           pready,
	input wire logic           pslverr,
	input wire vrei_fuses_t    fuse_straps,
	input wire vrei_dispatch_t dispatch,
	input wire logic [15:0]    reset_vector
);
	timeunit 1ns;
	timeprecision 100ps;

	logic [2:0]  up_cnt;
	logic [15:0] bb;
	logic        unl_wr;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	////////////////////////////////////////////////////////////
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			up_cnt <= 3'h0;
		else if (up_cnt != 3'h7)
			up_cnt <= up_cnt + 3'h1;
	end
	always_comb begin
		case (fuse_straps.boot_size_fuses)
			2'h0: bb = 16'h1C00;
			2'h1: bb = VREI_BOOT_BASE_1K;
			2'h2: bb = VREI_BOOT_BASE_512;
			default: bb = VREI_BOOT_BASE_256;
		endcase
	end
	assign unl_wr = psel && penable && pwrite && pstrb[0]
		&& paddr == VREI_OFS_MCU_CONTROL && pwdata[VREI_BIT_UNLOCK];

	vec_offset_a: assert property (
		dispatch.valid |-> dispatch.source != 2'h3
		&& dispatch.vector[6:0] == {4'h0, dispatch.source, 1'b0} + 7'h02)
		else $error("vector offset wrong");
	vec_base_a: assert property (
		dispatch.valid |-> dispatch.vector[15:7] == 9'h0
		|| dispatch.vector[15:7] == bb[15:7])
		else $error("vector base wrong");
	rst_vec_a: assert property (
		up_cnt == 3'h7 |-> reset_vector
		== (fuse_straps.boot_reset_fuse ? 16'h0000 : bb))
		else $error("reset vector wrong");
	unlock_mute_a: assert property (
		unl_wr && !dispatch.valid |-> ##2 (!$rose(dispatch.valid)) [*3])
		else $error("dispatch during unlock");
	quiet_reset_a: assert property (
		$rose(presetn) |-> (!dispatch.valid) [*4])
		else $error("dispatch right after reset");
	ready_a: assert property (psel |-> pready)
		else $error("pready low");
	bad_addr_a: assert property (
		psel && penable && (paddr > 8'h1C || paddr[1:0] != 2'h0)
		|-> pslverr && (pwrite || prdata == 32'h0))
		else $error("bad address not refused");
	upper_zero_a: assert property (
		psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");

	cover property (dispatch.valid && dispatch.source == VREI_SRC_EXT);
	cover property (dispatch.valid && dispatch.source == VREI_SRC_PC_LO);
	cover property (dispatch.valid && dispatch.source == VREI_SRC_PC_HI);
	cover property (unl_wr);
endmodule

bind vrei_top vrei_properties u_props (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .fuse_straps(fuse_straps), .dispatch(dispatch),
	.reset_vector(reset_vector));

/* tb/tb_top.sv */
// tb_top: random and corner tests of vrei_top with a core model.
// assumes the package, core model and checker bind are compiled first.
module tb_top
	import vrei_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	logic           pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic           ext_pin, io_on, irq_ack, slow, pin_wake, err;
	logic [7:0]     paddr;
	logic [3:0]     pstrb, idx;
	logic [31:0]    pwdata, prdata, q;
	logic [15:0]    pins, reset_vector, last_vec, m;
	logic [1:0]     last_src;
	vrei_fuses_t    fuse;
	vrei_dispatch_t dispatch;
	int             n_errors, checked, n_taken, t0;

	vrei_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_irq_pin(ext_pin), .pin_change_inputs(pins),
		.io_clock_running(io_on), .fuse_straps(fuse), .irq_ack(irq_ack),
		.dispatch(dispatch), .reset_vector(reset_vector),
		.pin_wake(pin_wake));
	vrei_core_model u_core (.pclk(pclk), .presetn(presetn),
		.dispatch(dispatch), .slow(slow), .irq_ack(irq_ack),
		.last_src(last_src), .last_vec(last_vec), .n_taken(n_taken));

	////////////////////////////////////////////////////////////
	function automatic logic [31:0] base_of(input logic [1:0] s);
		case (s)
			2'h0: return 32'h1C00;
			2'h1: return {16'h0, VREI_BOOT_BASE_1K};
			2'h2: return {16'h0, VREI_BOOT_BASE_512};
			default: return {16'h0, VREI_BOOT_BASE_256};
		endcase
	endfunction
	// table base, then two words per source after the reset slot
	function automatic logic [31:0] vec_of(input logic [1:0] src,
			input logic sel, input logic [1:0] s);
		return (sel ? base_of(s) : 32'h0) + 32'h2 + {29'h0, src, 1'b0};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("Error at %0t: saw %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic out_of_time();
		n_errors++;
		$display("Error at %0t: wait ran out", $time);
		end_of_test();
	endtask
	task automatic apb(input logic w, input logic [7:0] a,
			input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20)
			out_of_time();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 0);
	endtask
	task automatic do_reset(input vrei_fuses_t f);
		presetn <= 1'b0;
		fuse <= f;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask
	task automatic pulse_ext();
		ext_pin <= 1'b0;
		repeat (20) @(posedge pclk);
		ext_pin <= 1'b1;
		repeat (20) @(posedge pclk);
	endtask
	task automatic wait_take();
		int n;
		n = 0;
		while (n_taken == t0 && n < 80) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 80)
			out_of_time();
	endtask

	////////////////////////////////////////////////////////////
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		{psel, penable, pwrite, slow, presetn} = '0;
		{paddr, pwdata, pins} = '0;
		{ext_pin, io_on} = 2'h3;
		pstrb = 4'hF;
		fuse = '1;
		q = $urandom(75);
		do_reset('1);
		for (int a = 0; a < 32; a += 4) begin
			rd(8'(a));
			chk(q, 0);
		end
		wr(8'h24, 32'hFF);
		rd(8'h24);
		chk(q, 0);
		chk(32'(err), 1);
		chk(32'(reset_vector), 0);
		pstrb <= 4'hE;
		wr(VREI_OFS_MASK_LOW, 32'hFF);
		pstrb <= 4'hF;
		rd(VREI_OFS_MASK_LOW);
		chk(q, 0);
		$display("test registers done");
		wr(VREI_OFS_IRQ_ENABLE, 1);
		wr(VREI_OFS_CORE_CTRL, 1);
		for (int s = 1; s < 4; s++) begin
			wr(VREI_OFS_SENSE_CTRL, s);
			slow <= 1'($urandom);
			t0 = n_taken;
			pulse_ext();
			chk(n_taken - t0, s == 1 ? 2 : 1);
			chk(32'(last_vec), vec_of(2'h0, 1'b0, 2'h3));
		end
		wr(VREI_OFS_SENSE_CTRL, 0);
		t0 = n_taken;
		io_on <= 1'b0;
		ext_pin <= 1'b0;
		repeat (40) @(posedge pclk);
		chk(32'(n_taken - t0 > 2), 1);
		chk(32'(pin_wake), 1);
		rd(VREI_OFS_STATUS);
		chk(q, 2);
		ext_pin <= 1'b1;
		repeat (10) @(posedge pclk);
		chk(32'(pin_wake), 0);
		t0 = n_taken;
		repeat (20) @(posedge pclk);
		chk(n_taken - t0, 0);
		$display("test ext sense done");
		wr(VREI_OFS_CORE_CTRL, 0);
		wr(VREI_OFS_SENSE_CTRL, 2);
		for (int k = 0; k < 2; k++) begin
			io_on <= k[0];
			pulse_ext();
			rd(VREI_OFS_IRQ_FLAGS);
			chk(q, k);
		end
		wr(VREI_OFS_IRQ_FLAGS, 1);
		rd(VREI_OFS_IRQ_FLAGS);
		chk(q, 0);
		$display("test flags done");
		wr(VREI_OFS_IRQ_ENABLE, 32'hC0);
		wr(VREI_OFS_CORE_CTRL, 1);
		for (int k = 0; k < 8; k++) begin
			idx = (k == 0) ? 4'h0 : (k == 1) ? 4'hF : 4'($urandom);
			m = 16'h1 << idx;
			io_on <= k[0];
			slow <= k[1];
			wr(VREI_OFS_MASK_LOW, {24'h0, m[7:0]});
			wr(VREI_OFS_MASK_HIGH, {24'h0, m[15:8]});
			rd(VREI_OFS_MASK_HIGH);
			chk(q, {24'h0, m[15:8]});
			t0 = n_taken;
			pins[idx ^ 4'h1] <= ~pins[idx ^ 4'h1];
			repeat (20) @(posedge pclk);
			chk(n_taken - t0, 0);
			pins[idx] <= ~pins[idx];
			wait_take();
			chk(32'(last_src), idx[3] ? 2 : 1);
			chk(32'(last_vec), vec_of(idx[3] ? 2'h2 : 2'h1, 1'b0, 2'h3));
		end
		$display("test pin change done");
		for (int s = 0; s < 4; s++) begin
			do_reset({1'b0, 2'(s), 2'h3});
			wr(VREI_OFS_IRQ_ENABLE, 1);
			chk(32'(reset_vector), base_of(2'(s)));
			wr(VREI_OFS_SENSE_CTRL, 1);
			wr(VREI_OFS_CORE_CTRL, 1);
			wr(VREI_OFS_MCU_CONTROL, 1);
			wr(VREI_OFS_MCU_CONTROL, 2);
			rd(VREI_OFS_MCU_CONTROL);
			chk(q, 2);
			rd(VREI_OFS_CORE_CTRL);
			chk(q, 1);
			t0 = n_taken;
			ext_pin <= ~ext_pin;
			repeat (20) @(posedge pclk);
			chk(n_taken - t0, 0);
			wr(VREI_OFS_CORE_CTRL, 3);
			wait_take();
			chk(32'(last_vec), vec_of(2'h0, 1'b1, 2'(s)));
		end
		t0 = n_taken;
		ext_pin <= ~ext_pin;
		wr(VREI_OFS_MCU_CONTROL, 1);
		rd(VREI_OFS_STATUS);
		chk(32'(q[0]), 1);
		chk(n_taken - t0, 0);
		repeat (6) @(posedge pclk);
		rd(VREI_OFS_STATUS);
		chk(32'(q[0]), 0);
		chk(n_taken - t0, 1);
		wr(VREI_OFS_MCU_CONTROL, 0);
		rd(VREI_OFS_MCU_CONTROL);
		chk(q, 2);
		$display("test relocation done");
		end_of_test();
	end
endmodule
